// File: pkg/backlight_defines.svh
// Register offsets, field positions, reset values and timing for backlight regs
`ifndef BACKLIGHT_DEFINES_SVH
`define BACKLIGHT_DEFINES_SVH
`define ADDR_LEVEL       8'h00
`define ADDR_CONTROL     8'h01
`define ADDR_FAULT       8'h02
`define RST_LEVEL        8'h00
`define RST_CONTROL      8'h00
`define BIT_ENABLE       0
`define BIT_SEL_LO       1
`define BIT_SEL_HI       2
`define BIT_OPEN         7
`define BIT_SHORT        6
`define BIT_MULTI        5
`define BIT_SINGLE       4
`define BIT_ANY_LED      3
`define BIT_OVERCURRENT  2
`define BIT_THERMAL      1
`define BIT_SUPPLY_LOW   0
`define OC_TIME_MS       50
`define CLK_HZ           25000000
`define OC_CYCLES        ((`OC_TIME_MS * `CLK_HZ) / 1000)
`endif

// File: pkg/backlight_pkg.sv
// Types shared by the backlight register bank
package backlight_pkg;
    typedef enum logic [1:0] {
        SRC_PIN_A  = 2'b00,
        SRC_PIN_B  = 2'b01,
        SRC_REG    = 2'b10,
        SRC_DIRECT = 2'b11
    } source_select_type;
    typedef logic [7:0] byte_type;
endpackage

// File: src/backlight_control_fault_regs.sv
// Backlight level, control and latched fault registers
// How it works
// - Bits 2:1 select pin, register or direct
// - Bit 7 open fault, bit 6 short
// - Bit 5 when two or more channels fault
// - Bit 4 when exactly one channel faults
// - Bit 3 is OR of LED faults
// - Boost low over 50 ms sets bit 2
// - Boost restarts once overcurrent fault clears
// - Thermal trip sets bit 1, stops boost, LEDs
// - Stay off until temperature drops to 130C
// - Supply low sets bit 0, stops until recovered
// - Supply threshold comes from nonvolatile bits
// - Fault pin low while any bit set
// - Fault read or enable low clears all
`include "backlight_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module backlight_control_fault_regs
    import backlight_pkg::*;
#(
    parameter int CHANNELS  = 6,
    parameter int OC_CYCLES = `OC_CYCLES
) (
    input  wire logic                  sys_clk_i,     // 25 MHz clock
    input  wire logic                  sys_rst_i,     // Sync reset, high
    input  wire logic                  reg_wr_i,      // Register write strobe
    input  wire logic                  reg_rd_i,      // Register read strobe
    input  wire logic [7:0]            reg_addr_i,    // Register address
    input  wire backlight_pkg::byte_type reg_wdata_i, // Write data
    output logic      [7:0]            reg_rdata_o,   // Read data, next cycle
    input  wire logic                  pwm_pin_i,     // External PWM pin
    input  wire logic                  chip_en_i,     // Chip enable pin
    input  wire logic [CHANNELS-1:0]   led_open_i,    // Per-channel open
    input  wire logic [CHANNELS-1:0]   led_short_i,   // Per-channel short
    input  wire logic                  boost_low_i,   // Boost output too low
    input  wire logic                  temp_hot_i,    // At or above 150C
    input  wire logic                  temp_cool_i,   // Dropped to 130C
    input  wire logic                  supply_low_i,  // Input supply low
    output logic                       pwm_sel_pin_o, // Use pin duty cycle
    output logic                       pwm_direct_o,  // Pin passed through
    output logic [7:0]                 level_value_o, // Brightness level
    output logic                       chip_on_o,     // Chip active
    output logic                       boost_en_o,    // Boost converter on
    output logic                       led_en_o,      // LED outputs on
    output logic                       fault_n_o,     // Fault pin level
    output logic                       fault_oe_o     // Fault pin drive
);
    import backlight_pkg::*;

    // Pins cross in through two flops before use
    // Each pin is a slow level, so bits may settle one cycle apart; the
    // channel count behind bits 4 and 5 can latch a one-cycle miscount
    logic [2*CHANNELS+5:0] raw_sync1_reg;
    logic [2*CHANNELS+5:0] raw_sync2_reg;
    always_ff @(posedge sys_clk_i) begin
        raw_sync1_reg <= {pwm_pin_i, chip_en_i, led_open_i, led_short_i,
                          boost_low_i, temp_hot_i, temp_cool_i, supply_low_i};
        raw_sync2_reg <= raw_sync1_reg;
    end

    // Synced copies, in the order they were packed
    logic                pwm_s;
    logic                chip_en_s;
    logic [CHANNELS-1:0] open_s;
    logic [CHANNELS-1:0] short_s;
    logic                boost_low_s;
    logic                hot_s;
    logic                cool_s;
    logic                supply_low_s;
    assign {pwm_s, chip_en_s, open_s, short_s, boost_low_s, hot_s, cool_s,
            supply_low_s} = raw_sync2_reg;

    // Host-visible state; the fault bits live in fault_reg below
    logic [7:0]        level_reg;
    logic              light_enable_reg;
    source_select_type source_select_reg;
    logic [7:0]        fault_reg;
    logic [7:0]        fault_next;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            level_reg         <= `RST_LEVEL;
            light_enable_reg  <= 1'b0;
            source_select_reg <= SRC_PIN_A;
        end else if (reg_wr_i) begin
            // Fault and unmapped addresses take no write; control bits 7:3 drop
            if (reg_addr_i == `ADDR_LEVEL) begin
                level_reg <= reg_wdata_i;
            end
            if (reg_addr_i == `ADDR_CONTROL) begin
                light_enable_reg  <= reg_wdata_i[`BIT_ENABLE];
                source_select_reg <= source_select_type'(
                    reg_wdata_i[`BIT_SEL_HI:`BIT_SEL_LO]);
            end
        end
    end

    // Per-channel fault: any channel that reports open or short
    // Bits 4 and 5 count channels faulting now, not their history
    logic [CHANNELS-1:0] chan_fault;
    logic [3:0]          chan_count;
    always_comb begin
        chan_count = 4'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            chan_count = chan_count + 4'(chan_fault[i]);
        end
    end
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        assign chan_fault[g] = open_s[g] | short_s[g];
    end

    // Boost low must persist past the limit before it counts as overcurrent
    // The timer holds just past the limit instead of wrapping, and it
    // restarts whenever the boost is off, so after a restart a trip needs a fresh full count
    logic [31:0] oc_count_reg;
    logic        oc_event;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !boost_low_s || !boost_en_o) begin
            oc_count_reg <= 32'h0;
        end else if (oc_count_reg <= 32'(OC_CYCLES)) begin
            oc_count_reg <= oc_count_reg + 32'h1;
        end
    end
    // One cycle past the limit counts as having stayed low too long
    assign oc_event = (oc_count_reg > 32'(OC_CYCLES));

    // Events seen this cycle; each one sets its latched bit
    logic [7:0] fault_set;
    always_comb begin
        fault_set                   = 8'h00;
        fault_set[`BIT_OPEN]        = |open_s;
        fault_set[`BIT_SHORT]       = |short_s;
        fault_set[`BIT_MULTI]       = chan_count >= 4'h2;
        fault_set[`BIT_SINGLE]      = chan_count == 4'h1;
        fault_set[`BIT_ANY_LED]     = |chan_fault;
        fault_set[`BIT_OVERCURRENT] = oc_event;
        fault_set[`BIT_THERMAL]     = hot_s;
        fault_set[`BIT_SUPPLY_LOW]  = supply_low_s;
    end

    // Chip enable low clears the bits each cycle it stays low; live events still set them
    logic fault_clear;
    assign fault_clear = (reg_rd_i && reg_addr_i == `ADDR_FAULT)
                         || !chip_en_s;

    // A new event in the clearing cycle wins over the clear,
    // so nothing seen during a read is lost to that read
    always_comb begin
        fault_next = (fault_clear ? 8'h00 : fault_reg) | fault_set;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fault_reg <= 8'h00;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // Thermal hold survives the register clear; only the sensor releases it
    // A device still hot after a clear is reported again next cycle
    logic thermal_hold_reg;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            thermal_hold_reg <= 1'b0;
        end else if (hot_s) begin
            thermal_hold_reg <= 1'b1;
        end else if (cool_s) begin
            thermal_hold_reg <= 1'b0;
        end
    end

    // Supply threshold is set by nonvolatile trim outside; we see a level
    // In the pin modes the synced pin alone decides the chip state
    logic chip_on;
    assign chip_on = (source_select_reg == SRC_REG) ? light_enable_reg
                                                    : pwm_s;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            // Pin source is the reset default, so that flag starts high
            pwm_sel_pin_o <= 1'b1;
            pwm_direct_o  <= 1'b0;
            level_value_o <= `RST_LEVEL;
            chip_on_o     <= 1'b0;
            boost_en_o    <= 1'b0;
            led_en_o      <= 1'b0;
            fault_n_o     <= 1'b1;
            fault_oe_o    <= 1'b0;
            reg_rdata_o   <= 8'h00;
        end else begin
            // Source decode for the brightness path
            pwm_sel_pin_o <= source_select_reg inside {SRC_PIN_A, SRC_PIN_B};
            pwm_direct_o  <= source_select_reg == SRC_DIRECT;
            level_value_o <= level_reg;
            chip_on_o     <= chip_on;

            // Power stage gates: the boost also waits out a latched trip
            // Overcurrent latch off; restart follows the fault clear
            boost_en_o    <= chip_on && !fault_next[`BIT_OVERCURRENT]
                             && !thermal_hold_reg && !supply_low_s;
            led_en_o      <= chip_on && !thermal_hold_reg
                             && !supply_low_s;

            // Open drain: out of reset the level is low, the enable pulls the pin
            fault_n_o     <= 1'b0;
            fault_oe_o    <= |fault_next;

            // Each mapped address returns its register one cycle later, others zero; a read of
            // the fault register shows the bits as they were before the clear
            unique case (reg_addr_i)
                `ADDR_LEVEL:   reg_rdata_o <= level_reg;
                `ADDR_CONTROL: reg_rdata_o <= {5'h00, source_select_reg,
                                               light_enable_reg};
                `ADDR_FAULT:   reg_rdata_o <= fault_reg;
                default:       reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // backlight_control_fault_regs
`default_nettype wire

// File: bench/bl_props.sv
// Port checker for the backlight register bank
`timescale 1ns/100ps
`default_nettype none
module bl_props #(parameter int CHANNELS = 6, parameter int OC_CYCLES = 20) (
    input wire logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, chip_en_i,
    input wire logic [7:0] reg_addr_i, reg_rdata_o,
    input wire backlight_pkg::byte_type reg_wdata_i,
    input wire logic [CHANNELS-1:0] led_open_i, led_short_i,
    input wire logic boost_low_i, temp_hot_i, supply_low_i, pwm_sel_pin_o,
    input wire logic pwm_direct_o, chip_on_o, boost_en_o, led_en_o, fault_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [31:0] low_cnt;
    // Counts only while boost runs, like the trip timer
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !(boost_low_i && boost_en_o))
            low_cnt <= 32'h0;
        else if (low_cnt != 32'hffffffff)
            low_cnt <= low_cnt + 32'h1;
    end
    logic rd_f;
    assign rd_f = reg_rd_i && reg_addr_i == 8'h02;
    AST_SEL_PIN: assert property (reg_wr_i && reg_addr_i == 8'h01
        && !reg_wdata_i[2] |-> ##[1:2] pwm_sel_pin_o && !pwm_direct_o)
        else $error("pin source not selected");
    AST_SEL_DIRECT: assert property (reg_wr_i && reg_addr_i == 8'h01
        && reg_wdata_i[2:1] == 2'b11 |-> ##[1:2] pwm_direct_o)
        else $error("direct source not selected");
    AST_REG_OFF: assert property (reg_wr_i && reg_addr_i == 8'h01
        && reg_wdata_i[2:0] == 3'b100 |-> ##[1:3] !chip_on_o)
        else $error("chip left on");
    AST_OPEN_PIN: assert property ((|led_open_i && chip_en_i)[*5]
        |=> fault_oe_o) else $error("fault pin not driven");
    AST_RELEASE: assert property ((!chip_en_i && !(|led_open_i)
        && !(|led_short_i) && !temp_hot_i && !supply_low_i && !boost_low_i)[*5]
        |=> !fault_oe_o) else $error("fault pin not released");
    AST_HOT: assert property (temp_hot_i[*6] |=> !boost_en_o && !led_en_o)
        else $error("outputs on while hot");
    AST_SUPPLY: assert property (supply_low_i[*6] |=> !boost_en_o
        && !led_en_o) else $error("outputs on at low supply");
    AST_READ_PIN: assert property (rd_f |=> (|reg_rdata_o)
        == $past(fault_oe_o)) else $error("pin and fault bits differ");
    AST_LED_SUM: assert property (rd_f |=> reg_rdata_o[3] == (|reg_rdata_o[5:4])
        && reg_rdata_o[3] == (|reg_rdata_o[7:6])) else $error("led bits differ");
    AST_OC_TRIP: assert property (low_cnt == 32'(OC_CYCLES) |-> ##[1:8]
        !boost_en_o) else $error("boost not tripped");
endmodule // bl_props
bind backlight_control_fault_regs bl_props #(.CHANNELS(CHANNELS),
    .OC_CYCLES(OC_CYCLES)) chk (.*);
`default_nettype wire

// File: bench/reg_host.sv
// Host model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module reg_host (
    input  wire logic       sys_clk_i, // Bank clock
    input  wire logic [7:0] rdata_i,   // Read data
    output logic            wr_o,      // Write strobe
    output logic            rd_o,      // Read strobe
    output logic      [7:0] addr_o,    // Address
    output logic      [7:0] wdata_o    // Write data
);
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] q);
        @(posedge sys_clk_i) #1;
        {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(posedge sys_clk_i) #1;
        q = rdata_i;
        {wr_o, rd_o} = 2'b00;
        // Stale data is not left on the bus
        wdata_o = ~d;
    endtask
endmodule // reg_host
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the backlight register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst, wr, rd, pwm, en, low, hot, cool, vlow, sel, dir, on;
    logic boost, led, fn, foe;
    logic [7:0] addr, wd, rdat, lvl, q;
    logic [5:0] opn, sht;
    int err_count = 0, total_checks = 0;
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    backlight_control_fault_regs #(.OC_CYCLES(20)) dut (.sys_clk_i(clk),
        .sys_rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .pwm_pin_i(pwm), .chip_en_i(en),
        .led_open_i(opn), .led_short_i(sht), .boost_low_i(low),
        .temp_hot_i(hot), .temp_cool_i(cool), .supply_low_i(vlow),
        .pwm_sel_pin_o(sel), .pwm_direct_o(dir), .level_value_o(lvl),
        .chip_on_o(on), .boost_en_o(boost), .led_en_o(led), .fault_n_o(fn),
        .fault_oe_o(foe));
    reg_host host (.sys_clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wd));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd_chk(string n, logic [7:0] a, e);
        host.access(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_regs;
        chk("sel_pin", 8'h01, {7'h0, sel});
        rd_chk("unmapped", 8'h03, 8'h00);
        chk("pin_level", 8'h00, {7'h0, fn});
        host.access(1'b1, 8'h00, 8'ha5, q);
        host.access(1'b1, 8'h02, 8'hff, q);
        host.access(1'b1, 8'h01, 8'hfd, q);
        rd_chk("level", 8'h00, 8'ha5);
        chk("level_out", 8'ha5, lvl);
        rd_chk("control", 8'h01, 8'h05);
        rd_chk("fault_ro", 8'h02, 8'h00);
    endtask
    task automatic t_modes;
        logic [1:0] s;
        for (int m = 0; m < 8; m++) begin
            s = m[2:1];
            pwm = m[0];
            host.access(1'b1, 8'h01, {5'h0, s, ~m[0]}, q);
            settle;
            chk("sel_pin", {7'h0, s < 2}, {7'h0, sel});
            chk("direct", {7'h0, s == 3}, {7'h0, dir});
            chk("chip_on", {7'h0, s == 2 ? ~m[0] : m[0]}, {7'h0, on});
        end
        host.access(1'b1, 8'h01, 8'h05, q);
    endtask
    task automatic t_faults;
        opn = 6'h01;
        settle;
        chk("fault_pin", 8'h01, {7'h0, foe});
        rd_chk("one_open", 8'h02, 8'h98);
        opn = 6'h00;
        settle;
        rd_chk("latched", 8'h02, 8'h98);
        rd_chk("cleared", 8'h02, 8'h00);
        opn = 6'h01;
        sht = 6'h02;
        settle;
        rd_chk("two_chan", 8'h02, 8'he8);
        opn = 6'h00;
        sht = 6'h00;
        en = 0;
        settle;
        chk("released", 8'h00, {7'h0, foe});
        en = 1;
        settle;
        rd_chk("en_clear", 8'h02, 8'h00);
    endtask
    task automatic t_protect;
        hot = 1;
        settle;
        hot = 0;
        settle;
        chk("led_hot", 8'h00, {7'h0, led | boost});
        rd_chk("thermal", 8'h02, 8'h02);
        cool = 1;
        settle;
        cool = 0;
        chk("led_cool", 8'h01, {7'h0, led});
        vlow = 1;
        settle;
        chk("led_low", 8'h00, {7'h0, led | boost});
        vlow = 0;
        settle;
        chk("led_ok", 8'h01, {7'h0, led & boost});
        rd_chk("supply", 8'h02, 8'h01);
        low = 1;
        repeat (5) settle;
        low = 0;
        settle;
        chk("boost_oc", 8'h00, {7'h0, boost});
        rd_chk("overcur", 8'h02, 8'h04);
        settle;
        chk("boost_back", 8'h01, {7'h0, boost});
    endtask
    initial begin
        {rst, pwm, low, hot, cool, vlow, opn, sht} = 18'h20000;
        en = 1;
        repeat (12) @(posedge clk);
        #1 rst = 0;
        t_regs;
        t_modes;
        t_faults;
        t_protect;
        final_report;
    end
    initial begin
        #400000;
        err_count++;
        final_report;
    end
endmodule // testbench
`default_nettype wire
